// File: core/pfba_cfg.svh
// Constants of the programmable function block array
// How it works
// (R1) Four comparators compare two analog operands: greater, less, inside band, outside band.
// (R2) Each comparator has a hysteresis that is also the half-width of the band.
// (R3) Both comparator operands pass a configurable smoothing filter first; the code uses the reference for B unfiltered.
// (R4) Operand B is either the configured reference or any analog input.
// (R5) Six logic gates each combine up to three selected digital signals.
// (R6) Gate function is AND, OR, all equal or not all equal.
// (R7) Every gate input and the gate result can be inverted.
// (R8) A gate with two connected inputs evaluates over those two only.
// (R9) Gate inputs come from digital pins, fieldbus bits and all block outputs; the code has no fieldbus bits, select codes 21 to 31 raise the alarm.
// (R10) Two set/reset elements with gate-style inputs; set or reset priority selectable.
// (R11) Six timers: on delay, off delay, on and off delay, pulse.
// (R12) Timer delay has a preset and a selectable, extensible time base.
// (R13) Timer outputs leave the array to inverter functions or output drivers.
// (R14) Alarm unit forms AND or OR of up to six selected alarms.
// (R15) Trip unit forms AND or OR of up to six selected trips.
// (R16) Any block input may select any pin or any block output.
// (R17) Only timer outputs leave the array, so every chain ends in a timer.
// (R18) Each block output is readable as a status bit.
// (R19) Incomplete or inconsistent block setup raises the configuration alarm.
// (R20) A chain longer than ten blocks raises the configuration alarm.
// (R21) While the alarm stands all blocks are off and drive nothing.
// (R22) Greater mode: high above B plus hysteresis, low below B minus it, else hold.
// (R23) An active comparator without operand A raises the configuration alarm.
// (R24) All blocks evaluate together on each tick; reset clears all state to low.
`ifndef PFBA_CFG_SVH
`define PFBA_CFG_SVH
// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define N_CMP      4
`define N_LOG      6
`define N_FF       2
`define N_TMR      6
`define N_BLK      20
`define N_ANA      8
`define N_DIN      32
`define N_ALM      16
`define N_GRP      6
`define ANA_W      16
`define ASEL_W     4
`define DSEL_W     6
`define GSEL_W     5
`define TICK_W     16
`define ADDR_W     7
`define DEPTH_W    4
// ----------------------------------------------------------------------------
// Block output positions and digital select codes
// ----------------------------------------------------------------------------
`define OUT_CMP    0
`define OUT_LOG    4
`define OUT_FF     10
`define OUT_TMR    12
`define OUT_ALM    18
`define OUT_TRP    19
`define SEL_EXT    6'h20
// ----------------------------------------------------------------------------
// Word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define W_CMP      5'h00
`define W_LOG      5'h08
`define W_FF       5'h0E
`define W_TMR      5'h10
`define W_ALM      5'h16
`define W_TRP      5'h17
`define W_STAT     5'h18
`define N_CFG      24
`define CFG_RST    32'h0000_0000
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define F_ACT      0
`define C_FUNC     1
`define C_SELA     3
`define C_SELB     7
`define C_FLTA     11
`define C_FLTB     14
`define C_REF      0
`define C_HYS      16
`define L_FUNC     1
`define L_SEL      3
`define L_INV      21
`define L_NOT      24
`define FF_SET     1
`define FF_RST     7
`define FF_PRIO    13
`define T_MODE     1
`define T_SEL      3
`define T_BASE     9
`define T_PRE      16
`define G_OR       1
`define G_SEL      2
`define S_ERR      31
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ    40
`define TICK_US    1000
`define DEC_LAST   4'h9
`define CHAIN_MAX  4'hA
`define DEPTH_SAT  4'hF
`endif

// File: core/pfba_pkg.sv
// Types of the programmable function block array
`include "pfba_cfg.svh"
package pfba_pkg;
  typedef enum logic [1:0] {
    PFBA_GT = 2'h0,
    PFBA_LT = 2'h1,
    PFBA_EQ = 2'h2,
    PFBA_NE = 2'h3
  } pfba_cmp_e;

  typedef enum logic [1:0] {
    PFBA_AND = 2'h0,
    PFBA_OR  = 2'h1,
    PFBA_EQL = 2'h2,
    PFBA_NEQ = 2'h3
  } pfba_lgc_e;

  typedef enum logic [1:0] {
    PFBA_ON    = 2'h0,
    PFBA_OFF   = 2'h1,
    PFBA_ONOFF = 2'h2,
    PFBA_PULSE = 2'h3
  } pfba_tmr_e;

  typedef struct packed {
    logic [`N_CFG-1:0][31:0]        cfg;
    logic                           ack;
    logic [31:0]                    rdata;
    logic [`TICK_W-1:0]             tick_cnt;
    logic [2:0][3:0]                dec;
    logic [`N_DIN-1:0]              sync1;
    logic [`N_DIN-1:0]              sync2;
    logic [`N_CMP-1:0][`ANA_W-1:0]  fa;
    logic [`N_CMP-1:0][`ANA_W-1:0]  fb;
    logic [`N_BLK-1:0]              outv;
    logic [`N_TMR-1:0][15:0]        tcnt;
    logic [`N_TMR-1:0]              tprev;
    logic [`N_BLK-1:0][`DEPTH_W-1:0] depth;
    logic                           err;
  } pfba_state_s;
endpackage : pfba_pkg

// File: core/pfba_top.sv
// Function block array with Avalon-MM configuration slave
`include "pfba_cfg.svh"
module pfba_top #(
  parameter int unsigned TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic [`ADDR_W-1:0]            avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic [`N_DIN-1:0]             dig_in,
  input  wire logic [`N_ANA-1:0][`ANA_W-1:0] ana_in,
  input  wire logic [`N_ALM-1:0]             alarm_in,
  input  wire logic [`N_ALM-1:0]             trip_in,
  output logic      [`N_TMR-1:0]             timer_out,
  output logic      [`N_BLK-1:0]             block_status,
  output logic                               block_config_error_alarm
);
  localparam logic [`TICK_W-1:0] TICK_LAST = `TICK_W'(TICK_CYCLES - 1);

  pfba_pkg::pfba_state_s state_r;
  pfba_pkg::pfba_state_s state_nxt;

  logic                            req;
  logic [4:0]                      idx;
  logic                            tick;
  logic [3:0]                      bp;
  logic [63:0]                     dsrc;
  logic                            err_c;
  logic [`N_BLK-1:0]               act;
  logic [`N_BLK-1:0][`DEPTH_W-1:0] dmax;
  logic [`N_CMP-1:0][`ANA_W-1:0]   ax;
  logic [`N_CMP-1:0][`ANA_W-1:0]   bx;
  logic [`N_CMP-1:0][`ANA_W-1:0]   bop;
  logic signed [17:0]              av;
  logic signed [17:0]              hi;
  logic signed [17:0]              lo;
  logic [2:0]                      gu;
  logic [2:0]                      gv;
  logic                            all1;
  logic                            any1;
  logic                            gr;
  logic                            tin;
  logic                            tdone;
  logic                            fs;
  logic                            fr;
  logic [`DSEL_W-1:0]              sel;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [`ANA_W-1:0] ana_pick(
    input logic [`ASEL_W-1:0]             s,
    input logic [`N_ANA-1:0][`ANA_W-1:0]  a
  );
    if (s == '0 || s > `ASEL_W'(`N_ANA))
      ana_pick = '0;
    else
      ana_pick = a[3'(s - 1'b1)];
  endfunction : ana_pick

  function automatic logic dsel_bad(input logic [`DSEL_W-1:0] s);
    dsel_bad = (s > `DSEL_W'(`N_BLK)) && (s < `SEL_EXT);
  endfunction : dsel_bad

  function automatic logic [`DEPTH_W-1:0] dep_of(
    input logic [`DSEL_W-1:0]                s,
    input logic [`N_BLK-1:0][`DEPTH_W-1:0]   d
  );
    if (s != '0 && s <= `DSEL_W'(`N_BLK))
      dep_of = d[5'(s - 1'b1)];
    else
      dep_of = '0;
  endfunction : dep_of

  function automatic logic [`DEPTH_W-1:0] dmax2(
    input logic [`DEPTH_W-1:0] x,
    input logic [`DEPTH_W-1:0] y
  );
    dmax2 = (x > y) ? x : y;
  endfunction : dmax2

  // Alarm and trip combiners share one shape
  function automatic logic grp_eval(
    input logic [31:0]        w,
    input logic [`N_ALM-1:0]  src
  );
    logic             a;
    logic             o;
    logic [`GSEL_W-1:0] s;
    a = 1'b1;
    o = 1'b0;
    for (int j = 0; j < `N_GRP; j++)
    begin
      s = w[`G_SEL + `GSEL_W * j +: `GSEL_W];
      if (s != '0 && s <= `GSEL_W'(`N_ALM))
      begin
        a = a & src[4'(s - 1'b1)];
        o = o | src[4'(s - 1'b1)];
      end
    end
    grp_eval = w[`G_OR] ? o : a;
  endfunction : grp_eval

  function automatic logic grp_bad(input logic [31:0] w);
    logic               any;
    logic               bad;
    logic [`GSEL_W-1:0] s;
    any = 1'b0;
    bad = 1'b0;
    for (int j = 0; j < `N_GRP; j++)
    begin
      s = w[`G_SEL + `GSEL_W * j +: `GSEL_W];
      any = any | (s != '0);
      bad = bad | (s > `GSEL_W'(`N_ALM));
    end
    grp_bad = bad | ~any;
  endfunction : grp_bad

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    req = avs_read | avs_write;
    idx = avs_address[`ADDR_W-1:2];
    // One wait cycle, so read data always comes from a register
    avs_waitrequest = req & ~state_r.ack;
    state_nxt.ack = req & ~state_r.ack;
    if (req && !state_r.ack)
    begin
      state_nxt.rdata = '0;
      if (avs_read && idx < 5'(`N_CFG))
        state_nxt.rdata = state_r.cfg[idx];
      else if (avs_read && idx == `W_STAT)
      begin
        state_nxt.rdata[`N_BLK-1:0] = state_r.outv; // [R18]
        state_nxt.rdata[`S_ERR] = state_r.err;
      end
    end
    if (avs_write && state_r.ack && idx < 5'(`N_CFG))
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (avs_byteenable[k])
          state_nxt.cfg[idx][8*k +: 8] = avs_writedata[8*k +: 8];
      end
    end

    // Pins are asynchronous to the array clock
    state_nxt.sync1 = dig_in;
    state_nxt.sync2 = state_r.sync1;

    // Tick and decade time bases
    tick = (state_r.tick_cnt == TICK_LAST);
    state_nxt.tick_cnt = tick ? '0 : state_r.tick_cnt + 1'b1;
    bp[0] = tick;
    for (int k = 0; k < 3; k++)
    begin
      bp[k+1] = bp[k] & (state_r.dec[k] == `DEC_LAST); // [R12]
      if (bp[k])
        state_nxt.dec[k] = (state_r.dec[k] == `DEC_LAST) ? '0 : state_r.dec[k] + 1'b1;
    end

    // Any pin or any block output may feed a block; index 0 means unused
    dsrc = {state_r.sync2, 11'h000, state_r.outv, 1'b0}; // [R9] [R16]

    // Configuration check and chain depth
    err_c = 1'b0;
    act = '0;
    dmax = '0;
    for (int i = 0; i < `N_CMP; i++)
    begin
      act[`OUT_CMP+i] = state_r.cfg[`W_CMP+2*i][`F_ACT];
      if (act[`OUT_CMP+i] &&
          (state_r.cfg[`W_CMP+2*i][`C_SELA +: `ASEL_W] == '0 || // [R23]
           state_r.cfg[`W_CMP+2*i][`C_SELA +: `ASEL_W] > `ASEL_W'(`N_ANA) ||
           state_r.cfg[`W_CMP+2*i][`C_SELB +: `ASEL_W] > `ASEL_W'(`N_ANA)))
        err_c = 1'b1; // [R19]
    end
    for (int i = 0; i < `N_LOG; i++)
    begin
      act[`OUT_LOG+i] = state_r.cfg[`W_LOG+i][`F_ACT];
      gu = '0;
      for (int j = 0; j < 3; j++)
      begin
        sel = state_r.cfg[`W_LOG+i][`L_SEL + `DSEL_W*j +: `DSEL_W];
        gu[j] = (sel != '0);
        dmax[`OUT_LOG+i] = dmax2(dmax[`OUT_LOG+i], dep_of(sel, state_r.depth));
        if (act[`OUT_LOG+i] && dsel_bad(sel))
          err_c = 1'b1; // [R19]
      end
      if (act[`OUT_LOG+i] && gu == '0)
        err_c = 1'b1; // [R19]
    end
    for (int i = 0; i < `N_FF; i++)
    begin
      act[`OUT_FF+i] = state_r.cfg[`W_FF+i][`F_ACT];
      for (int j = 0; j < 2; j++)
      begin
        sel = state_r.cfg[`W_FF+i][`FF_SET + `DSEL_W*j +: `DSEL_W];
        dmax[`OUT_FF+i] = dmax2(dmax[`OUT_FF+i], dep_of(sel, state_r.depth));
        if (act[`OUT_FF+i] && dsel_bad(sel))
          err_c = 1'b1; // [R19]
      end
      if (act[`OUT_FF+i] && state_r.cfg[`W_FF+i][`FF_SET +: 2*`DSEL_W] == '0)
        err_c = 1'b1; // [R19]
    end
    for (int i = 0; i < `N_TMR; i++)
    begin
      act[`OUT_TMR+i] = state_r.cfg[`W_TMR+i][`F_ACT];
      sel = state_r.cfg[`W_TMR+i][`T_SEL +: `DSEL_W];
      dmax[`OUT_TMR+i] = dep_of(sel, state_r.depth);
      if (act[`OUT_TMR+i] && (sel == '0 || dsel_bad(sel)))
        err_c = 1'b1; // [R19]
    end
    act[`OUT_ALM] = state_r.cfg[`W_ALM][`F_ACT];
    act[`OUT_TRP] = state_r.cfg[`W_TRP][`F_ACT];
    if ((act[`OUT_ALM] && grp_bad(state_r.cfg[`W_ALM])) ||
        (act[`OUT_TRP] && grp_bad(state_r.cfg[`W_TRP])))
      err_c = 1'b1; // [R19]
    // Depth settles a few cycles after a change; a loop saturates and is caught
    for (int b = 0; b < `N_BLK; b++)
    begin
      state_nxt.depth[b] = (dmax[b] == `DEPTH_SAT) ? `DEPTH_SAT : dmax[b] + 1'b1;
      if (act[b] && state_r.depth[b] > `CHAIN_MAX)
        err_c = 1'b1; // [R20]
    end
    state_nxt.err = err_c;

    // Evaluation
    av = '0;
    hi = '0;
    lo = '0;
    gv = '0;
    all1 = 1'b0;
    any1 = 1'b0;
    gr = 1'b0;
    tin = 1'b0;
    tdone = 1'b0;
    fs = 1'b0;
    fr = 1'b0;
    ax = '0;
    bx = '0;
    bop = '0;
    if (err_c)
    begin
      state_nxt.outv = '0; // [R21]
      state_nxt.tcnt = '0;
      state_nxt.tprev = '0;
    end
    else if (tick)
    begin
      // All blocks read last tick's outputs, so order never matters
      for (int i = 0; i < `N_CMP; i++) // [R1] [R24]
      begin
        ax[i] = ana_pick(state_r.cfg[`W_CMP+2*i][`C_SELA +: `ASEL_W], ana_in);
        bx[i] = ana_pick(state_r.cfg[`W_CMP+2*i][`C_SELB +: `ASEL_W], ana_in);
        state_nxt.fa[i] = 16'(state_r.fa[i] + 16'(($signed({ax[i][15], ax[i]}) -
          $signed({state_r.fa[i][15], state_r.fa[i]})) >>>
          state_r.cfg[`W_CMP+2*i][`C_FLTA +: 3])); // [R3]
        state_nxt.fb[i] = 16'(state_r.fb[i] + 16'(($signed({bx[i][15], bx[i]}) -
          $signed({state_r.fb[i][15], state_r.fb[i]})) >>>
          state_r.cfg[`W_CMP+2*i][`C_FLTB +: 3])); // [R3]
        bop[i] = (state_r.cfg[`W_CMP+2*i][`C_SELB +: `ASEL_W] == '0) ?
          state_r.cfg[`W_CMP+2*i+1][`C_REF +: `ANA_W] : state_nxt.fb[i]; // [R4]
        av = $signed({{2{state_nxt.fa[i][15]}}, state_nxt.fa[i]});
        hi = $signed({{2{bop[i][15]}}, bop[i]}) +
          $signed({2'h0, state_r.cfg[`W_CMP+2*i+1][`C_HYS +: `ANA_W]}); // [R2]
        lo = $signed({{2{bop[i][15]}}, bop[i]}) -
          $signed({2'h0, state_r.cfg[`W_CMP+2*i+1][`C_HYS +: `ANA_W]}); // [R2]
        if (!act[`OUT_CMP+i])
          state_nxt.outv[`OUT_CMP+i] = 1'b0;
        else
        begin
          unique case (pfba_pkg::pfba_cmp_e'(state_r.cfg[`W_CMP+2*i][`C_FUNC +: 2]))
            pfba_pkg::PFBA_GT:
            begin
              if (av > hi)
                state_nxt.outv[`OUT_CMP+i] = 1'b1; // [R22]
              else if (av < lo)
                state_nxt.outv[`OUT_CMP+i] = 1'b0; // [R22]
            end
            pfba_pkg::PFBA_LT:
            begin
              if (av < lo)
                state_nxt.outv[`OUT_CMP+i] = 1'b1;
              else if (av > hi)
                state_nxt.outv[`OUT_CMP+i] = 1'b0;
            end
            pfba_pkg::PFBA_EQ:
              state_nxt.outv[`OUT_CMP+i] = (av > lo) && (av < hi);
            pfba_pkg::PFBA_NE:
              state_nxt.outv[`OUT_CMP+i] = (av < lo) || (av > hi);
          endcase
        end
      end
      for (int i = 0; i < `N_LOG; i++) // [R5]
      begin
        for (int j = 0; j < 3; j++)
        begin
          sel = state_r.cfg[`W_LOG+i][`L_SEL + `DSEL_W*j +: `DSEL_W];
          gu[j] = (sel != '0);
          gv[j] = dsrc[sel] ^ state_r.cfg[`W_LOG+i][`L_INV+j]; // [R7]
        end
        // Unused inputs drop out of every function
        all1 = &(gv | ~gu); // [R8]
        any1 = |(gv & gu); // [R8]
        unique case (pfba_pkg::pfba_lgc_e'(state_r.cfg[`W_LOG+i][`L_FUNC +: 2])) // [R6]
          pfba_pkg::PFBA_AND: gr = all1;
          pfba_pkg::PFBA_OR:  gr = any1;
          pfba_pkg::PFBA_EQL: gr = all1 | ~any1;
          pfba_pkg::PFBA_NEQ: gr = ~(all1 | ~any1);
        endcase
        state_nxt.outv[`OUT_LOG+i] = act[`OUT_LOG+i] &
          (gr ^ state_r.cfg[`W_LOG+i][`L_NOT]); // [R7]
      end
      for (int i = 0; i < `N_FF; i++) // [R10]
      begin
        fs = dsrc[state_r.cfg[`W_FF+i][`FF_SET +: `DSEL_W]];
        fr = dsrc[state_r.cfg[`W_FF+i][`FF_RST +: `DSEL_W]];
        if (!act[`OUT_FF+i])
          state_nxt.outv[`OUT_FF+i] = 1'b0;
        else if (fs && fr)
          state_nxt.outv[`OUT_FF+i] = ~state_r.cfg[`W_FF+i][`FF_PRIO];
        else if (fs)
          state_nxt.outv[`OUT_FF+i] = 1'b1;
        else if (fr)
          state_nxt.outv[`OUT_FF+i] = 1'b0;
      end
      for (int i = 0; i < `N_TMR; i++) // [R11]
      begin
        tin = dsrc[state_r.cfg[`W_TMR+i][`T_SEL +: `DSEL_W]];
        tdone = (state_r.tcnt[i] >= state_r.cfg[`W_TMR+i][`T_PRE +: 16]); // [R12]
        state_nxt.tprev[i] = tin;
        if (bp[state_r.cfg[`W_TMR+i][`T_BASE +: 2]] && !tdone)
          state_nxt.tcnt[i] = state_r.tcnt[i] + 1'b1;
        if (!act[`OUT_TMR+i])
        begin
          state_nxt.outv[`OUT_TMR+i] = 1'b0;
          state_nxt.tcnt[i] = '0;
        end
        else
        begin
          unique case (pfba_pkg::pfba_tmr_e'(state_r.cfg[`W_TMR+i][`T_MODE +: 2]))
            pfba_pkg::PFBA_ON:
            begin
              if (!tin)
              begin
                state_nxt.outv[`OUT_TMR+i] = 1'b0;
                state_nxt.tcnt[i] = '0;
              end
              else if (tdone)
                state_nxt.outv[`OUT_TMR+i] = 1'b1;
            end
            pfba_pkg::PFBA_OFF:
            begin
              if (tin || !state_r.outv[`OUT_TMR+i])
              begin
                state_nxt.outv[`OUT_TMR+i] = tin;
                state_nxt.tcnt[i] = '0;
              end
              else if (tdone)
                state_nxt.outv[`OUT_TMR+i] = 1'b0;
            end
            pfba_pkg::PFBA_ONOFF:
            begin
              if (tin == state_r.outv[`OUT_TMR+i])
                state_nxt.tcnt[i] = '0;
              else if (tdone)
              begin
                state_nxt.outv[`OUT_TMR+i] = tin;
                state_nxt.tcnt[i] = '0;
              end
            end
            pfba_pkg::PFBA_PULSE:
            begin
              // Retrigger is ignored while a pulse runs
              if (!state_r.outv[`OUT_TMR+i])
              begin
                state_nxt.tcnt[i] = '0;
                state_nxt.outv[`OUT_TMR+i] = tin & ~state_r.tprev[i];
              end
              else if (tdone)
                state_nxt.outv[`OUT_TMR+i] = 1'b0;
            end
          endcase
        end
      end
      state_nxt.outv[`OUT_ALM] = act[`OUT_ALM] & grp_eval(state_r.cfg[`W_ALM], alarm_in); // [R14]
      state_nxt.outv[`OUT_TRP] = act[`OUT_TRP] & grp_eval(state_r.cfg[`W_TRP], trip_in); // [R15]
    end
  end

  // ----------------------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      state_r <= '0; // [R24]
    else
      state_r <= state_nxt;
  end

  assign avs_readdata             = state_r.rdata;
  assign timer_out                = state_r.outv[`OUT_TMR +: `N_TMR]; // [R13] [R17]
  assign block_status             = state_r.outv; // [R18]
  assign block_config_error_alarm = state_r.err; // [R19]
endmodule : pfba_top

// File: dv/pfba_assertions.sv
// Port checker of the function block array
module pfba_assertions (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [5:0]  timer_out,
  input wire logic [19:0] block_status,
  input wire logic        block_config_error_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // Bus and output relations
  // ------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  a_wait_first:
    assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one:
    assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_reset_clear:
    assert property (disable iff (1'h0) reset |=> block_status == 20'h0_0000
      && !block_config_error_alarm)
    else $error("reset left state");
  a_err_off:
    assert property (block_config_error_alarm |-> block_status == 20'h0_0000
      && timer_out == 6'h00)
    else $error("blocks active in error");
  a_tmr_status:
    assert property (timer_out == block_status[17:12])
    else $error("timer output differs");
  // Read data is loaded from the state seen in the request's first cycle
  a_stat_bits:
    assert property (avs_read && !avs_waitrequest && avs_address[6:2] == 5'h18
      |-> avs_readdata[19:0] == $past(block_status))
    else $error("status bits differ");
  a_stat_err:
    assert property (avs_read && !avs_waitrequest && avs_address[6:2] == 5'h18
      |-> avs_readdata[31] == $past(block_config_error_alarm))
    else $error("status error bit differs");
  a_unmapped_read:
    assert property (avs_read && !avs_waitrequest && avs_address[6:2] > 5'h18
      |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : pfba_assertions

// File: dv/pfba_top_tb.sv
// Self-checking bench of the function block array
module pfba_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clock = 1'h0, reset = 1'h1, rd = 1'h0, wr = 1'h0, wt, cfe;
  logic [3:0]       be = 4'hF, e;
  logic [6:0]       adr = 7'h00;
  logic [31:0]      wd = 32'h0000_0000, din = 32'h0000_0000, rdat, q;
  logic [7:0][15:0] ana = '0;
  logic [15:0]      alm = 16'h0000;
  logic [5:0]       tmo;
  logic [19:0]      bs;
  int               miscompares = 0, checks_done = 0;
  // Short tick keeps the run brief; every wait below is counted in clock cycles, ten to a tick
  pfba_top #(.TICK_CYCLES(10)) u_pfba_top (.clock(clock), .reset(reset),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt), .dig_in(din),
    .ana_in(ana), .alarm_in(alm), .trip_in(alm), .timer_out(tmo), .block_status(bs),
    .block_config_error_alarm(cfe));
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clock);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do
      @(posedge clock);
    while (wt !== 1'h0);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : acc
  task automatic rc(input logic [6:0] a, input logic [31:0] x);
    acc(1'h0, a, 32'h0000_0000);
    chk(q, x);
  endtask : rc
  task automatic tcp(input int n, input logic [4:0] x);
    repeat (n) @(posedge clock);
    chk(tmo[5:1], x);
  endtask : tcp
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (9000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    rc(7'h00, 32'h0000_0000);
    rc(7'h7C, 32'h0000_0000);
    rc(7'h60, 32'h0000_0000);
    // Timers 1 to 5 on pin 0: on, on with slow base, off, on and off, pulse
    for (int k = 1; k < 6; k++)
      acc(1'h1, 7'(64 + 4 * k), 32'h0002_0101 | (k > 2 ? k - 2 : 0) << 1 | (k == 2) << 9);
    din <= 32'h0000_0001;
    tcp(14, 5'h14);
    tcp(20, 5'h1D);
    din <= 32'h0000_0000;
    tcp(14, 5'h0C);
    tcp(20, 5'h00);
    // Gate 1 on pins 1 and 2 leaves the array only through timer 0
    acc(1'h1, 7'h40, 32'h0000_0029);
    din <= 32'h0000_0006;
    for (int k = 0; k < 9; k++)
    begin
      acc(1'h1, 7'h20, 32'h0000_4509 | (k % 4) << 1 | (k / 4) << 21 | (k / 8) << 24);
      e = (k < 4) ? 4'h7 : (k < 8) ? 4'hA : 4'h1;
      repeat (60) @(posedge clock);
      chk(bs[4], e[k % 4]);
      chk(tmo[0], e[k % 4]);
    end
    // Comparator 1: reference 100, hysteresis 10, then every function at 120
    acc(1'h1, 7'h04, 32'h000A_0064);
    for (int k = 0; k < 9; k++)
    begin
      ana[0] <= 16'(k < 5 ? (k == 3 ? 85 : (k == 0 ? 115 : 105 + 5 * (k % 2 == 0))) : 120);
      acc(1'h1, 7'h00, 32'h0000_0009 | (k > 4 ? k - 5 : 0) << 1);
      repeat (40) @(posedge clock);
      chk(bs[0], k < 3 || k == 5 || k == 8);
    end
    ana[1] <= 16'h008C;
    acc(1'h1, 7'h00, 32'h0000_0109);
    repeat (40) @(posedge clock);
    chk(bs[0], 1'h0);
    alm <= 16'h0001;
    for (int k = 0; k < 4; k++)
    begin
      acc(1'h1, 7'(88 + 4 * (k / 2)), 32'h0000_0105 | (k % 2) << 1);
      repeat (40) @(posedge clock);
      chk(bs[18 + k / 2], k % 2);
    end
    // Flip-flop 1: set on pin 1, reset on pin 2, both high; set wins, then reset wins
    for (int k = 0; k < 2; k++)
    begin
      acc(1'h1, 7'h38, 32'h0000_1143 | k << 13);
      repeat (40) @(posedge clock);
      chk(bs[10], k == 0);
    end
    acc(1'h1, 7'h08, 32'h0000_0001);
    repeat (40) @(posedge clock);
    chk(cfe, 1'h1);
    rc(7'h60, 32'h8000_0000);
    acc(1'h1, 7'h08, 32'h0000_0000);
    repeat (40) @(posedge clock);
    chk(cfe, 1'h0);
    // Gate 2 feeding itself is an endless chain
    acc(1'h1, 7'h24, 32'h0000_0031);
    repeat (40) @(posedge clock);
    chk(cfe, 1'h1);
    acc(1'h1, 7'h0C, 32'h1234_5678);
    be <= 4'h1;
    acc(1'h1, 7'h0C, 32'hFFFF_FFFF);
    be <= 4'hF;
    rc(7'h0C, 32'h1234_56FF);
    report_and_stop();
  end
endmodule : pfba_top_tb
bind pfba_top pfba_assertions u_pfba_assertions (.clock(clock), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_out(timer_out),
  .block_status(block_status), .block_config_error_alarm(block_config_error_alarm));
